// >>> fifo_pkg.sv
// Purpose: Shared constants and types for the dual-port 18-bit flag FIFO
// Assumes: Pin-level control inputs other than the clocks and the shared pin are active low, as on the device pins
// Notes:   Timing counts are in cycles of the 125 MHz system clock, except RETX_HOLD_CYC in read edges
package fifo_pkg;

    localparam int          DATA_W        = 18;
    localparam int          DEPTH_DEF     = 32768;
    localparam int          OFS_W         = 16;
    localparam logic [15:0] OFS_DEF_SMALL = 16'h007F;   // 127 locations
    localparam logic [15:0] OFS_DEF_LARGE = 16'h03FF;   // 1,023 locations
    localparam logic [17:0] DATA_RST      = 18'h0_0000;
    localparam int          SYNC_STAGES   = 2;
    localparam int          RETX_HOLD_CYC = 1;          // read edges flag is forced

    typedef enum logic {
        MODE_STANDARD,
        MODE_FALL_THROUGH
    } timing_mode_t;

    // Control pin group sampled together by the system clock; active low except the clocks and shared pin
    typedef struct packed {
        logic wclk;
        logic rclk;
        logic write_en_n;
        logic read_en_n;
        logic serial_load_enable_n;
        logic offset_load_select_n;
        logic fall_through_serial_pin;
        logic full_reset_n;
        logic pointer_reset_n;
        logic retransmit_request_n;
        logic output_enable_n;
    } pin_ctrl_t;

    localparam pin_ctrl_t PINS_IDLE = '{wclk: 1'b0, rclk: 1'b0, write_en_n: 1'b1,
        read_en_n: 1'b1, serial_load_enable_n: 1'b1, offset_load_select_n: 1'b1,
        fall_through_serial_pin: 1'b0, full_reset_n: 1'b1, pointer_reset_n: 1'b1,
        retransmit_request_n: 1'b1, output_enable_n: 1'b1};

endpackage : fifo_pkg

// >>> flag_fifo.sv
// Purpose: Deep 18-bit FIFO with standard and fall-through timing and flags
// Assumes: Write and read clocks arrive as pins and are edge-detected on clk
// Notes:   Both ports live in the clk domain once their pins are synchronised
//
// Overview of operation
// - Either reset zeroes pointers and output register
// - Full reset latches mode, default offset, method
// - Pointer reset keeps mode, method and offsets
// - Retransmit on read edge rewinds read pointer
// - Retransmit briefly forces empty/not-ready indication
// - Retransmit leaves write pointer and settings alone
// - Shared pin: mode in reset, serial data after
// - Serial enable shifts one offset bit per write clock edge
// - Write stores word, or offset when loading parallel
// - Read returns word, or offset when selected
// - Write and read data are 18 bits
// - Output enable drives or floats read data
// - Load select in reset picks 127 or 1,023
// - Load select redirects accesses to offset registers
// - Standard mode: full flag at maximum count
// - Fall-through mode: input ready while space exists
// - Empty flag, or output-valid in fall-through mode
// - Almost-full low above capacity minus m
// - Almost-empty low below offset n
// - Half-full shows count above half capacity
// - Depth is 32,768 or 65,536 words
// - Fall-through first word appears without read enable
// - Load low gives 127 parallel, high 1,023 serial
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module word_store
    import fifo_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = DEPTH_DEF,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Control
    input  wire logic             clear,
    input  wire logic             rewind,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    // Status
    output logic [AW:0]           level
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      level_r;
    logic             push;
    logic             pop;

    if (DEPTH != (1 << AW)) begin : g_chk
        $error("word_store depth must be a power of two");
    end

    assign in_ready  = (level_r < (AW+1)'(DEPTH));
    assign out_valid = (level_r != '0);
    assign out_data  = mem[rd_ptr_r];
    assign level     = level_r;
    assign push      = in_valid & in_ready & ~clear;
    assign pop       = out_valid & out_ready & ~clear & ~rewind;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r <= '0;
        end else if (clear) begin
            wr_ptr_r <= '0;
        end else if (push) begin
            wr_ptr_r <= wr_ptr_r + AW'(1);
        end
    end

    // Rewind keeps the write pointer; every location below the write pointer is live again
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_ptr_r <= '0;
            level_r  <= '0;
        end else if (clear) begin
            rd_ptr_r <= '0;
            level_r  <= '0;
        end else if (rewind) begin
            rd_ptr_r <= '0;
            level_r  <= {1'b0, wr_ptr_r} + (AW+1)'(push);
        end else begin
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
            level_r <= level_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : word_store

////////////////////////////////////////////////////////////////////////////////
module flag_fifo
    import fifo_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEF
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Device pins, active low where named so
    input  wire logic              wclk_pin,
    input  wire logic              rclk_pin,
    input  wire logic              write_en_n,
    input  wire logic              read_en_n,
    input  wire logic              serial_load_enable_n,
    input  wire logic              offset_load_select_n,
    input  wire logic              fall_through_serial_pin,
    input  wire logic              full_reset_n,
    input  wire logic              pointer_reset_n,
    input  wire logic              retransmit_request_n,
    input  wire logic              output_enable_n,
    input  wire logic [DATA_W-1:0] write_data_in,
    // Read data, three-state as value plus enable
    output logic [DATA_W-1:0]      read_data_out,
    output logic                   read_data_oe,
    // Flags, active low
    output logic                   full_space_flag_n,
    output logic                   empty_valid_flag_n,
    output logic                   almost_full_flag_n,
    output logic                   almost_empty_flag_n,
    output logic                   half_full_flag_n
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH != 32768 && DEPTH != 65536) begin : g_chk
        $error("flag_fifo depth must be 32768 or 65536");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; stage one feeds only stage two
    pin_ctrl_t             pins_raw;
    pin_ctrl_t             pins_s1_r;
    pin_ctrl_t             pins_r;
    logic [DATA_W-1:0]     wdata_s1_r;
    logic [DATA_W-1:0]     wdata_r;
    logic                  wclk_d_r;
    logic                  rclk_d_r;

    assign pins_raw = '{wclk: wclk_pin, rclk: rclk_pin, write_en_n: write_en_n,
        read_en_n: read_en_n, serial_load_enable_n: serial_load_enable_n,
        offset_load_select_n: offset_load_select_n,
        fall_through_serial_pin: fall_through_serial_pin, full_reset_n: full_reset_n,
        pointer_reset_n: pointer_reset_n, retransmit_request_n: retransmit_request_n,
        output_enable_n: output_enable_n};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pins_s1_r  <= PINS_IDLE;
            pins_r     <= PINS_IDLE;
            wdata_s1_r <= DATA_RST;
            wdata_r    <= DATA_RST;
            wclk_d_r   <= 1'b0;
            rclk_d_r   <= 1'b0;
        end else begin
            pins_s1_r  <= pins_raw;
            pins_r     <= pins_s1_r;
            wdata_s1_r <= write_data_in;
            wdata_r    <= wdata_s1_r;
            wclk_d_r   <= pins_r.wclk;
            rclk_d_r   <= pins_r.rclk;
        end
    end

    logic w_edge;
    logic r_edge;
    logic in_full_rst;
    logic in_ptr_rst;
    logic ofs_sel;
    logic wr_req;
    logic rd_req;

    assign w_edge      = pins_r.wclk & ~wclk_d_r;
    assign r_edge      = pins_r.rclk & ~rclk_d_r;
    assign in_full_rst = ~pins_r.full_reset_n;
    assign in_ptr_rst  = in_full_rst | ~pins_r.pointer_reset_n;
    assign ofs_sel     = ~pins_r.offset_load_select_n & ~in_full_rst;
    assign wr_req      = w_edge & ~pins_r.write_en_n;
    assign rd_req      = r_edge & ~pins_r.read_en_n;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration latched during full reset
    timing_mode_t      mode_r;
    logic              serial_prog_r;
    logic [OFS_W-1:0]  empty_ofs_r;
    logic [OFS_W-1:0]  full_ofs_r;
    logic              wr_ofs_pick_r;
    logic              fall;

    assign fall = (mode_r == MODE_FALL_THROUGH);

    // Offsets change only on full reset or an explicit load
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_r        <= MODE_STANDARD;
            serial_prog_r <= 1'b0;
            empty_ofs_r   <= OFS_DEF_SMALL;
            full_ofs_r    <= OFS_DEF_SMALL;
            wr_ofs_pick_r <= 1'b0;
        end else if (in_full_rst) begin
            mode_r        <= pins_r.fall_through_serial_pin ? MODE_FALL_THROUGH
                                                            : MODE_STANDARD;
            serial_prog_r <= pins_r.offset_load_select_n;
            empty_ofs_r   <= pins_r.offset_load_select_n ? OFS_DEF_LARGE
                                                         : OFS_DEF_SMALL;
            full_ofs_r    <= pins_r.offset_load_select_n ? OFS_DEF_LARGE
                                                         : OFS_DEF_SMALL;
            wr_ofs_pick_r <= 1'b0;
        end else if (w_edge && ~pins_r.serial_load_enable_n && ofs_sel) begin
            // Empty offset shifts out into full offset, MSB first in
            {full_ofs_r, empty_ofs_r} <= {full_ofs_r[OFS_W-2:0], empty_ofs_r,
                                          pins_r.fall_through_serial_pin};
        end else if (wr_req && ofs_sel && !serial_prog_r) begin
            if (wr_ofs_pick_r) begin
                full_ofs_r <= OFS_W'(wdata_r);
            end else begin
                empty_ofs_r <= OFS_W'(wdata_r);
            end
            wr_ofs_pick_r <= ~wr_ofs_pick_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic              st_in_ready;
    logic              st_out_valid;
    logic [DATA_W-1:0] st_out_data;
    logic [AW:0]       level;
    logic              pop;
    logic              retx;
    logic              out_valid_r;

    assign retx = r_edge & ~pins_r.retransmit_request_n & ~in_ptr_rst;
    assign pop  = r_edge & st_out_valid & ~ofs_sel & ~retx &
                  (fall ? (~out_valid_r | ~pins_r.read_en_n)
                        : ~pins_r.read_en_n);

    word_store #(
        .WIDTH     (DATA_W),
        .DEPTH     (DEPTH),
        .AW        (AW)
    ) u_store (
        .clk       (clk),
        .resetn    (resetn),
        .clear     (in_ptr_rst),
        .rewind    (retx),
        .in_valid  (wr_req & ~ofs_sel),
        .in_ready  (st_in_ready),
        .in_data   (wdata_r),
        .out_valid (st_out_valid),
        .out_ready (pop),
        .out_data  (st_out_data),
        .level     (level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output register and read-side state
    logic [DATA_W-1:0] q_r;
    logic              rd_ofs_pick_r;
    logic              retx_hold_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q_r           <= DATA_RST;
            out_valid_r   <= 1'b0;
            rd_ofs_pick_r <= 1'b0;
            retx_hold_r   <= 1'b0;
        end else if (in_ptr_rst) begin
            q_r           <= DATA_RST;
            out_valid_r   <= 1'b0;
            rd_ofs_pick_r <= 1'b0;
            retx_hold_r   <= 1'b0;
        end else if (retx) begin
            out_valid_r   <= 1'b0;
            retx_hold_r   <= 1'b1;
        end else if (r_edge) begin
            retx_hold_r <= 1'b0;
            if (pop) begin
                q_r         <= st_out_data;
                out_valid_r <= 1'b1;
            end else if (rd_req && ofs_sel) begin
                q_r           <= DATA_W'(rd_ofs_pick_r ? full_ofs_r : empty_ofs_r);
                rd_ofs_pick_r <= ~rd_ofs_pick_r;
            end else if (rd_req) begin
                out_valid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs and flags
    logic [AW:0] af_limit;

    assign af_limit = (AW+1)'(DEPTH) - (AW+1)'(full_ofs_r);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            read_data_out       <= DATA_RST;
            read_data_oe        <= 1'b0;
            full_space_flag_n   <= 1'b1;
            empty_valid_flag_n  <= 1'b0;
            almost_full_flag_n  <= 1'b1;
            almost_empty_flag_n <= 1'b0;
            half_full_flag_n    <= 1'b1;
        end else begin
            read_data_out <= q_r;
            read_data_oe  <= ~pins_r.output_enable_n;
            if (fall) begin
                full_space_flag_n  <= ~st_in_ready;
                empty_valid_flag_n <= ~out_valid_r | retx_hold_r;
            end else begin
                full_space_flag_n  <= st_in_ready;
                empty_valid_flag_n <= st_out_valid & ~retx_hold_r;
            end
            almost_full_flag_n  <= ~(level > af_limit);
            almost_empty_flag_n <= ~(level < (AW+1)'(empty_ofs_r));
            half_full_flag_n    <= ~(level > (AW+1)'(DEPTH / 2));
        end
    end

endmodule : flag_fifo

// >>> flag_fifo_monitor.sv
// Purpose: Concurrent checks on the flag FIFO pins
// Assumes: Pin effects land within four clk of their cause
// Notes:   Mode is tracked here from the shared pin during full reset
`timescale 1ns/100ps
module flag_fifo_monitor
    import fifo_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEF
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              resetn,
    // Pins
    input wire logic              wclk_pin,
    input wire logic              rclk_pin,
    input wire logic              fall_through_serial_pin,
    input wire logic              full_reset_n,
    input wire logic              pointer_reset_n,
    input wire logic              retransmit_request_n,
    input wire logic              output_enable_n,
    // Outputs
    input wire logic [DATA_W-1:0] read_data_out,
    input wire logic              read_data_oe,
    input wire logic              full_space_flag_n,
    input wire logic              empty_valid_flag_n,
    input wire logic              almost_full_flag_n,
    input wire logic              almost_empty_flag_n,
    input wire logic              half_full_flag_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    logic [1:0] wq_r, rq_r;
    logic [3:0] wage_r, rage_r, sage_r;
    logic       ft_r;
    wire logic  rrise = (rq_r == 2'b01);
    // Link clocks rise every ten clk, so quiet must open well inside that period
    wire logic  quiet = (wage_r > 4'h4) && (rage_r > 4'h4) && (sage_r > 4'h4);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wq_r <= 2'b00;
            rq_r <= 2'b00;
        end else begin
            wq_r <= {wq_r[0], wclk_pin};
            rq_r <= {rq_r[0], rclk_pin};
        end
    end
    // Saturating ages since the last cause of any data or flag change
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {wage_r, rage_r, sage_r} <= 12'h000;
        end else begin
            wage_r <= (wq_r == 2'b01) ? 4'h0 : wage_r + {3'h0, wage_r != 4'hF};
            rage_r <= rrise ? 4'h0 : rage_r + {3'h0, rage_r != 4'hF};
            sage_r <= !(full_reset_n && pointer_reset_n) ? 4'h0
                    : sage_r + {3'h0, sage_r != 4'hF};
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ft_r <= 1'b0;
        end else if (!full_reset_n) begin
            ft_r <= fall_through_serial_pin;
        end
    end
    a_oe_on:
        assert property (!output_enable_n [*5] |-> read_data_oe) else $error("data not driven");
    a_oe_off:
        assert property (output_enable_n [*5] |-> !read_data_oe) else $error("data driven");
    a_full_rst_clear:
        assert property (!full_reset_n [*6] |-> read_data_out == DATA_RST
            && !almost_empty_flag_n && half_full_flag_n && almost_full_flag_n)
            else $error("full reset left state");
    a_ptr_rst_clear:
        assert property (!pointer_reset_n [*6] |-> read_data_out == DATA_RST
            && !almost_empty_flag_n) else $error("pointer reset left state");
    a_data_has_cause:
        assert property ($changed(read_data_out) |-> !quiet) else $error("data moved alone");
    a_flags_have_cause:
        assert property ($changed({full_space_flag_n, empty_valid_flag_n, almost_full_flag_n,
            almost_empty_flag_n, half_full_flag_n}) |-> !quiet) else $error("flag moved alone");
    a_rt_std_empty:
        assert property (rrise && !retransmit_request_n && !ft_r |-> ##[1:8] !empty_valid_flag_n)
            else $error("retransmit did not show empty");
    a_rt_ft_unready:
        assert property (rrise && !retransmit_request_n && ft_r |-> ##[1:8] empty_valid_flag_n)
            else $error("retransmit did not drop ready");
    c_rt: cover property (rrise && !retransmit_request_n);
    c_ft_valid: cover property (ft_r && !empty_valid_flag_n);
    c_oe: cover property ($rose(read_data_oe));
endmodule : flag_fifo_monitor

// >>> fifo_far_model.sv
// Purpose: Producer and consumer logic on the far side of the FIFO pins
// Assumes: Link clocks run free at 80 ns; pins move on falling link edges
// Notes:   A released data bus shows the inverse of the last word
`timescale 1ns/100ps
module fifo_far_model
    import fifo_pkg::*;
(
    // Link clocks
    output logic                   wclk_pin,
    output logic                   rclk_pin,
    // Controls and data
    output logic                   write_en_n,
    output logic                   read_en_n,
    output logic                   serial_load_enable_n,
    output logic                   offset_load_select_n,
    output logic                   fall_through_serial_pin,
    output logic                   retransmit_request_n,
    output logic [DATA_W-1:0]      write_data_in,
    input  wire logic [DATA_W-1:0] read_data_out
);
    initial begin
        {write_en_n, read_en_n, serial_load_enable_n, offset_load_select_n} = 4'hF;
        fall_through_serial_pin = 1'b0;
        retransmit_request_n = 1'b1;
        write_data_in = 18'h0_0000;
        wclk_pin = 1'b0;
        #13;
        forever #40 wclk_pin = ~wclk_pin;
    end
    initial begin
        rclk_pin = 1'b0;
        #29;
        forever #40 rclk_pin = ~rclk_pin;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic cfg(input logic ft, input logic ld);
        fall_through_serial_pin = ft;
        offset_load_select_n = ~ld;
    endtask : cfg
    task automatic wr(input logic [DATA_W-1:0] d, input logic ld);
        @(negedge wclk_pin);
        write_en_n = 1'b0;
        offset_load_select_n = ~ld;
        write_data_in = d;
        @(negedge wclk_pin);
        write_en_n = 1'b1;
        offset_load_select_n = 1'b1;
        write_data_in = ~d;
    endtask : wr
    task automatic rd(input logic ld, output logic [DATA_W-1:0] q);
        @(negedge rclk_pin);
        read_en_n = 1'b0;
        offset_load_select_n = ~ld;
        @(negedge rclk_pin);
        read_en_n = 1'b1;
        offset_load_select_n = 1'b1;
        @(posedge rclk_pin);
        #1 q = read_data_out;
    endtask : rd
    // Full offset goes first so the empty offset ends in the low register
    task automatic sload(input logic [31:0] v);
        for (int i = 31; i >= 0; i--) begin
            @(negedge wclk_pin);
            serial_load_enable_n = 1'b0;
            offset_load_select_n = 1'b0;
            fall_through_serial_pin = v[i];
        end
        @(negedge wclk_pin);
        serial_load_enable_n = 1'b1;
        offset_load_select_n = 1'b1;
        fall_through_serial_pin = ~v[0];
    endtask : sload
    task automatic rt();
        @(negedge rclk_pin);
        retransmit_request_n = 1'b0;
        @(negedge rclk_pin);
        retransmit_request_n = 1'b1;
    endtask : rt
endmodule : fifo_far_model

// >>> flag_fifo_tb.sv
// Purpose: Self-checking bench for the flag FIFO in both timing modes
// Assumes: Reset pins held 8 clk; flags read a dozen clk after access
// Notes:   Full device depth, so thresholds are programmed low to be reached
`timescale 1ns/100ps
module flag_fifo_tb;
    import fifo_pkg::*;
    localparam int DEPTH = DEPTH_DEF;
    logic              clk, resetn, full_reset_n, pointer_reset_n, output_enable_n;
    logic              wclk_pin, rclk_pin, write_en_n, read_en_n, serial_load_enable_n;
    logic              offset_load_select_n, fall_through_serial_pin, retransmit_request_n;
    logic              read_data_oe, full_space_flag_n, empty_valid_flag_n;
    logic              almost_full_flag_n, almost_empty_flag_n, half_full_flag_n;
    logic [DATA_W-1:0] write_data_in, read_data_out, q;
    logic [4:0]        fl;
    int                miscompares = 0;
    int                n_compared = 0;
    int                cyc = 0;
    assign fl = {full_space_flag_n, empty_valid_flag_n, almost_full_flag_n,
                 almost_empty_flag_n, half_full_flag_n};
    flag_fifo #(.DEPTH(DEPTH)) uut (.clk, .resetn, .wclk_pin, .rclk_pin, .write_en_n,
        .read_en_n, .serial_load_enable_n, .offset_load_select_n, .fall_through_serial_pin,
        .full_reset_n, .pointer_reset_n, .retransmit_request_n, .output_enable_n,
        .write_data_in, .read_data_out, .read_data_oe, .full_space_flag_n,
        .empty_valid_flag_n, .almost_full_flag_n, .almost_empty_flag_n, .half_full_flag_n);
    fifo_far_model far (.wclk_pin, .rclk_pin, .write_en_n, .read_en_n, .serial_load_enable_n,
        .offset_load_select_n, .fall_through_serial_pin, .retransmit_request_n,
        .write_data_in, .read_data_out);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    task automatic frst(input logic ft, input logic ld);
        far.cfg(ft, ld);
        idle(1);
        full_reset_n = 1'b0;
        idle(8);
        full_reset_n = 1'b1;
        idle(4);
        far.cfg(1'b0, 1'b0);
        idle(8);
    endtask : frst
    task automatic wrap_up();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        {resetn, full_reset_n, pointer_reset_n, output_enable_n} = 4'b0111;
        idle(10);
        resetn = 1'b1;
        frst(1'b0, 1'b0);
        chk(read_data_out, DATA_RST);
        chk(18'(fl), 18'h0_0015);
        far.rd(1'b1, q);
        chk(q, 18'h0_03FF);
        far.rd(1'b1, q);
        chk(q, 18'h0_03FF);
        $display("test defaults done");
        for (int i = 0; i < 3; i++)
            far.wr(18'h2_A5A0 + 18'(i), 1'b0);
        idle(12);
        chk(18'(fl), 18'h0_001D);
        for (int i = 0; i < 4; i++) begin
            far.rd(1'b0, q);
            chk(q, 18'h2_A5A0 + 18'(i < 3 ? i : 2));
        end
        far.rt();
        idle(12);
        for (int i = 0; i < 3; i++) begin
            far.rd(1'b0, q);
            chk(q, 18'h2_A5A0 + 18'(i));
        end
        far.wr(18'h1_2345, 1'b0);
        far.rd(1'b0, q);
        chk(q, 18'h1_2345);
        $display("test standard data and retransmit done");
        far.sload({16'h7FFE, 16'h0002});
        far.rd(1'b1, q);
        chk(q, 18'h0_0002);
        far.rd(1'b1, q);
        chk(q, 18'h0_7FFE);
        far.wr(18'h0_0001, 1'b0);
        far.wr(18'h0_0002, 1'b0);
        idle(12);
        chk(18'(fl), 18'h0_001F);
        far.wr(18'h0_0003, 1'b0);
        idle(12);
        chk(18'(fl), 18'h0_001B);
        pointer_reset_n = 1'b0;
        idle(8);
        pointer_reset_n = 1'b1;
        idle(8);
        chk(read_data_out, DATA_RST);
        chk(18'(fl), 18'h0_0015);
        far.rd(1'b1, q);
        chk(q, 18'h0_0002);
        $display("test offsets and pointer reset done");
        frst(1'b1, 1'b1);
        chk(18'(fl), 18'h0_000D);
        far.wr(18'h0_0010, 1'b1);
        far.wr(18'h0_0020, 1'b1);
        far.rd(1'b1, q);
        chk(q, 18'h0_0010);
        far.rd(1'b1, q);
        chk(q, 18'h0_0020);
        far.wr(18'h0_1111, 1'b0);
        far.wr(18'h0_2222, 1'b0);
        idle(30);
        chk(read_data_out, 18'h0_1111);
        chk(18'(empty_valid_flag_n), 18'h0_0000);
        far.rd(1'b0, q);
        chk(q, 18'h0_2222);
        far.rt();
        idle(30);
        chk(read_data_out, 18'h0_1111);
        $display("test fall-through done");
        output_enable_n = 1'b0;
        idle(6);
        chk(18'(read_data_oe), 18'h0_0001);
        output_enable_n = 1'b1;
        idle(6);
        chk(18'(read_data_oe), 18'h0_0000);
        $display("test output enable done");
        wrap_up();
    end
endmodule : flag_fifo_tb

bind flag_fifo flag_fifo_monitor #(.DEPTH(DEPTH)) mon (.clk, .resetn, .wclk_pin, .rclk_pin,
    .fall_through_serial_pin, .full_reset_n, .pointer_reset_n, .retransmit_request_n,
    .output_enable_n, .read_data_out, .read_data_oe, .full_space_flag_n, .empty_valid_flag_n,
    .almost_full_flag_n, .almost_empty_flag_n, .half_full_flag_n);
